/* File: cmpc_regs.svh */
// Register offsets, field positions, reset values for the comparator control block
// Assumes a 32-bit APB slave, one aligned word per register
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH
`define CMPC_OFS_CTRL_A 12'h000
`define CMPC_OFS_CTRL_B 12'h004
`define CMPC_OFS_MIRROR 12'h008
`define CMPC_OFS_PORT 12'h00c
`define CMPC_OFS_IRQ 12'h010
`define CMPC_A_ENABLE 7
`define CMPC_A_RESULT 6
`define CMPC_A_PIN_OE 5
`define CMPC_A_INVERT 4
`define CMPC_A_SPEED 2
`define CMPC_A_HYST 1
`define CMPC_A_SYNC 0
`define CMPC_B_RISE 7
`define CMPC_B_FALL 6
`define CMPC_B_PLUS_HI 5
`define CMPC_B_PLUS_LO 4
`define CMPC_B_MINUS 0
`define CMPC_A_WMASK 8'hb7
`define CMPC_B_WMASK 8'hf1
`define CMPC_A_RESET 8'h04
`define CMPC_B_RESET 8'h00
`endif

/* File: cmpc_pkg.sv */
// Types shared by the comparator control block
// Assumes cmpc_regs.svh for numeric constants
package cmpc_pkg;
    typedef struct packed {
        logic enable;
        logic pin_oe;
        logic invert;
        logic speed_select;
        logic hysteresis;
        logic timer_sync;
    } cmpc_ctrl_a_s;
    typedef struct packed {
        logic rise_en;
        logic fall_en;
        logic [1:0] plus_sel;
        logic minus_sel;
    } cmpc_ctrl_b_s;
    typedef enum logic [1:0] {
        CMPC_PLUS_PIN,
        CMPC_PLUS_RESISTIVE,
        CMPC_PLUS_FIXED,
        CMPC_PLUS_GROUND
    } cmpc_plus_e;
endpackage

/* File: cmpc_top.sv */
// Comparator control and status logic with APB register access
// Assumes the analog core output, timer clock and port pins are asynchronous; all else on clock
// What this block does
// - Enable bit 7 of control A switches comparator, resets zero.
// - Result bit 6 reads plus above minus, reversed when inverted.
// - Pin output enable routes result to pin when direction clear, ignoring enable.
// - Pin output enable clear keeps result internal, port drives pin.
// - Invert bit 4 inverts result, resets zero.
// - Speed bit 2 resets one for fast; zero selects low power.
// - Hysteresis bit 1 enables hysteresis, resets zero.
// - Sync bit set updates timer and pin result on timer clock falls.
// - Sync bit clear passes result to timer and pin unlatched.
// - Rise enable sets interrupt flag on each result low-to-high.
// - Fall enable sets interrupt flag on each result high-to-low.
// - Plus select 00 pin, 01 resistive, 10 fixed reference.
// - Minus select zero picks first pin, one second pin.
// - Mirror register bit 0 copies result; other bits zero.
// - Unimplemented bits ignore writes, read zero.
// - Port reads return zero for analog-configured pins.
// - Edges are seen after polarity and enable gating.
// - Internal result registered each cycle; pin unlatched unless synced.
// - Sync latching uses the prescaled timer clock.
`timescale 1ns/10ps
`include "cmpc_regs.svh"
module cmpc_top
    import cmpc_pkg::*;
#(
    parameter int PORT_W = 6
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic analog_decision,
    input wire logic timer_clk_prescaled,
    input wire logic pin_direction_bit,
    input wire logic port_latch_out,
    input wire logic [PORT_W-1:0] port_pins_in,
    input wire logic [PORT_W-1:0] analog_select,
    output logic cmp_powered,
    output logic cmp_speed_select,
    output logic cmp_hysteresis_enable,
    output logic [1:0] plus_input_select,
    output logic minus_input_select,
    output logic timer_gate_result,
    output logic pin_out,
    output logic pin_oe,
    output logic cmp_irq_flag
);
    cmpc_ctrl_a_s ctrl_a_ff;
    cmpc_ctrl_b_s ctrl_b_ff;
    logic dec_s1_ff, dec_s2_ff;
    logic tclk_s1_ff, tclk_s2_ff, tclk_d_ff;
    logic result_ff;
    logic result_q_ff;
    logic sync_result_ff;
    logic irq_flag_ff;
    logic [PORT_W-1:0] port_s1_ff, port_s2_ff;
    logic [31:0] prdata_ff;
    logic nxt_result;
    logic ext_result;
    logic wr_en, rd_en;
    logic edge_hit;
    logic [7:0] rd_a, rd_b;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_ff;

    // Analog decision, timer clock and port pin synchronisers
    always_ff @(posedge clock) begin
        dec_s1_ff <= analog_decision;
        dec_s2_ff <= dec_s1_ff;
        tclk_s1_ff <= timer_clk_prescaled;
        tclk_s2_ff <= tclk_s1_ff;
        tclk_d_ff <= tclk_s2_ff;
        port_s1_ff <= port_pins_in;
        port_s2_ff <= port_s1_ff;
    end

    // Disabled comparator decides low, then polarity applies
    assign nxt_result = (ctrl_a_ff.enable & dec_s2_ff) ^ ctrl_a_ff.invert;

    always_ff @(posedge clock) begin
        if (rst) begin
            result_ff <= 1'b0;
            result_q_ff <= 1'b0;
        end else begin
            result_ff <= nxt_result;
            result_q_ff <= result_ff;
        end
    end

    // Latch on falling edge of the prescaled timer clock
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_result_ff <= 1'b0;
        end else if (tclk_d_ff && !tclk_s2_ff) begin
            sync_result_ff <= result_ff;
        end
    end

    // Unsynced path still passes the analog domain crossing first
    assign ext_result = ctrl_a_ff.timer_sync ? sync_result_ff : nxt_result;
    assign timer_gate_result = ext_result;
    assign pin_oe = !pin_direction_bit;
    assign pin_out = ctrl_a_ff.pin_oe ? ext_result : port_latch_out;

    assign cmp_powered = ctrl_a_ff.enable;
    assign cmp_speed_select = ctrl_a_ff.speed_select;
    assign cmp_hysteresis_enable = ctrl_a_ff.hysteresis;
    assign plus_input_select = ctrl_b_ff.plus_sel;
    assign minus_input_select = ctrl_b_ff.minus_sel;

    // Control registers
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_a_ff <= '0;
            ctrl_a_ff.speed_select <= 1'b1;
        end else if (wr_en && paddr == `CMPC_OFS_CTRL_A) begin
            ctrl_a_ff.enable <= pwdata[`CMPC_A_ENABLE];
            ctrl_a_ff.pin_oe <= pwdata[`CMPC_A_PIN_OE];
            ctrl_a_ff.invert <= pwdata[`CMPC_A_INVERT];
            ctrl_a_ff.speed_select <= pwdata[`CMPC_A_SPEED];
            ctrl_a_ff.hysteresis <= pwdata[`CMPC_A_HYST];
            ctrl_a_ff.timer_sync <= pwdata[`CMPC_A_SYNC];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_b_ff <= '0;
        end else if (wr_en && paddr == `CMPC_OFS_CTRL_B) begin
            ctrl_b_ff.rise_en <= pwdata[`CMPC_B_RISE];
            ctrl_b_ff.fall_en <= pwdata[`CMPC_B_FALL];
            ctrl_b_ff.plus_sel <= pwdata[`CMPC_B_PLUS_HI:`CMPC_B_PLUS_LO];
            ctrl_b_ff.minus_sel <= pwdata[`CMPC_B_MINUS];
        end
    end

    // Edge detect on the gated, polarity-applied result
    assign edge_hit = (ctrl_b_ff.rise_en && result_ff && !result_q_ff)
        || (ctrl_b_ff.fall_en && !result_ff && result_q_ff);

    // Writing one to bit 0 clears; a same-cycle edge wins
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_flag_ff <= 1'b0;
        end else if (edge_hit) begin
            irq_flag_ff <= 1'b1;
        end else if (wr_en && paddr == `CMPC_OFS_IRQ && pwdata[0]) begin
            irq_flag_ff <= 1'b0;
        end
    end
    assign cmp_irq_flag = irq_flag_ff;

    always_comb begin
        rd_a = {ctrl_a_ff.enable, result_ff, ctrl_a_ff.pin_oe, ctrl_a_ff.invert, 1'b0,
                ctrl_a_ff.speed_select, ctrl_a_ff.hysteresis, ctrl_a_ff.timer_sync};
        rd_b = {ctrl_b_ff.rise_en, ctrl_b_ff.fall_en, ctrl_b_ff.plus_sel, 3'h0, ctrl_b_ff.minus_sel};
    end

    // Read data register, unmapped reads return zero
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_ff <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == `CMPC_OFS_CTRL_A) begin
                prdata_ff <= {24'h0, rd_a};
            end else if (paddr == `CMPC_OFS_CTRL_B) begin
                prdata_ff <= {24'h0, rd_b};
            end else if (paddr == `CMPC_OFS_MIRROR) begin
                prdata_ff <= {31'h0, result_ff};
            end else if (paddr == `CMPC_OFS_PORT) begin
                prdata_ff <= 32'(port_s2_ff & ~analog_select);
            end else if (paddr == `CMPC_OFS_IRQ) begin
                prdata_ff <= {31'h0, irq_flag_ff};
            end else begin
                prdata_ff <= 32'h0;
            end
        end
    end
    logic unused_rd;
    assign unused_rd = rd_en;
endmodule

/* File: cmpc_props.sv */
// Checker on the comparator control top ports
// Assumes a zero-wait APB slave and the offsets of cmpc_regs.svh
`timescale 1ns/10ps
`include "cmpc_regs.svh"
module cmpc_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pin_direction_bit,
    input wire logic pin_oe,
    input wire logic cmp_powered,
    input wire logic cmp_speed_select,
    input wire logic cmp_hysteresis_enable,
    input wire logic [1:0] plus_input_select,
    input wire logic minus_input_select,
    input wire logic cmp_irq_flag
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire wr = psel && penable && pwrite;
    wire wa = wr && paddr == `CMPC_OFS_CTRL_A;
    wire wb = wr && paddr == `CMPC_OFS_CTRL_B;
    pin_dir_a: assert property (pin_oe == !pin_direction_bit) else $error("pin enable bad");
    rst_val_a: assert property ($fell(rst) |-> cmp_speed_select && !cmp_powered && !cmp_irq_flag)
        else $error("reset value bad");
    en_wr_a: assert property (wa |=> cmp_powered == $past(pwdata[7])) else $error("enable bad");
    sp_wr_a: assert property (wa |=> cmp_speed_select == $past(pwdata[2])) else $error("speed bad");
    hy_wr_a: assert property (wa |=> cmp_hysteresis_enable == $past(pwdata[1])) else $error("hyst bad");
    pl_wr_a: assert property (wb |=> plus_input_select == $past(pwdata[5:4])) else $error("plus bad");
    mn_wr_a: assert property (wb |=> minus_input_select == $past(pwdata[0])) else $error("minus bad");
    flag_hold_a: assert property (cmp_irq_flag && !(wr && paddr == `CMPC_OFS_IRQ && pwdata[0]) |=> cmp_irq_flag)
        else $error("flag lost");
endmodule
bind cmpc_top cmpc_props chk(.*);

/* File: cmpc_far.sv */
// Far side: analog comparator core and prescaled timer clock
// Assumes the bench sets the input level and the timer run control
`timescale 1ns/10ps
module cmpc_far (
    input wire logic lvl,
    input wire logic run,
    output logic analog_decision,
    output logic timer_clk_prescaled
);
    assign #3 analog_decision = lvl;
    initial timer_clk_prescaled = 1'h1;
    // Timer clock parks high when stopped, so no stray falling edge
    always #17 timer_clk_prescaled = run ? !timer_clk_prescaled : 1'h1;
endmodule

/* File: cmpc_top_tb.sv */
// Bench for the comparator control block
// Assumes cmpc_far on the analog and timer inputs
`timescale 1ns/10ps
module cmpc_top_tb;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, pin_direction_bit, port_latch_out, lvl, run, res;
    logic analog_decision, timer_clk_prescaled, cmp_powered, cmp_speed_select, cmp_hysteresis_enable;
    logic minus_input_select, timer_gate_result, pin_out, pin_oe, cmp_irq_flag;
    logic [1:0] plus_input_select;
    logic [11:0] paddr;
    logic [5:0] port_pins_in, analog_select;
    logic [31:0] pwdata, prdata, a, b, q[$];
    int n_mismatch, comparisons, i;
    cmpc_top dut(.*);
    cmpc_far far(.*);
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        n_mismatch += int'(g !== e);
        if (g !== e) $display("wrong value %0t got %h exp %h", $time, g, e);
    endtask
    task complete_run(input int bad);
        n_mismatch += bad;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Reads note their expected word; the monitor compares it
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        if (!w) q.push_back(d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, ad, w ? d : 32'h0};
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        for (i = 0; i < 50 && pready !== 1'h1; i++) @(posedge clock);
        if (i == 50) complete_run(1);
        {psel, penable} <= 2'h0;
    endtask
    initial forever #2 clock = !clock;
    always @(posedge clock) if (psel && penable && !pwrite && pready === 1'h1) chk(prdata, q.pop_front());
    initial begin
        {clock, rst, psel, penable, pwrite, paddr, pwdata, lvl, run, pin_direction_bit, port_latch_out,
            port_pins_in, analog_select} = {2'h1, 63'h0};
        void'($urandom(32'h5390));
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        apb(1'h0, 12'h0, 32'h4);
        apb(1'h0, 12'h4, 32'h0);
        apb(1'h0, 12'h18, 32'h0);
        for (int k = 0; k < 8; k++) begin
            {a, b} = {$urandom, $urandom};
            {lvl, pin_direction_bit, port_latch_out, port_pins_in, analog_select} <= 15'($urandom);
            apb(1'h1, 12'h0, a);
            apb(1'h1, 12'h4, b);
            repeat (6) @(posedge clock);
            res = (a[7] & lvl) ^ a[4];
            apb(1'h0, 12'h0, {24'h0, a[7:0] & 8'hb7 | {1'h0, res, 6'h0}});
            apb(1'h0, 12'h4, {24'h0, b[7:0] & 8'hf1});
            apb(1'h0, 12'h8, {31'h0, res});
            apb(1'h0, 12'hc, {26'h0, port_pins_in & ~analog_select});
            chk({plus_input_select, minus_input_select, cmp_speed_select, cmp_hysteresis_enable, cmp_powered},
                {b[5:4], b[0], a[2:1], a[7]});
            if (!a[0]) chk({pin_out, timer_gate_result}, {a[5] ? res : port_latch_out, res});
            chk({pready, pslverr, pin_oe}, {2'h2, !pin_direction_bit});
        end
        apb(1'h1, 12'h0, 32'h80);
        for (int k = 0; k < 4; k++) begin
            lvl <= k[0];
            apb(1'h1, 12'h4, k[1] ? 32'h40 : 32'h80);
            apb(1'h1, 12'h10, 32'h1);
            apb(1'h0, 12'h10, 32'h0);
            lvl <= !k[0];
            repeat (8) @(posedge clock);
            chk(cmp_irq_flag, 32'(k[0] == k[1]));
        end
        run <= 1'h1;
        apb(1'h1, 12'h0, 32'ha1);
        repeat (30) @(posedge clock);
        run <= 1'h0;
        repeat (30) @(posedge clock);
        lvl <= 1'h1;
        repeat (8) @(posedge clock);
        apb(1'h0, 12'h8, 32'h1);
        chk({pin_out, timer_gate_result}, 2'h0);
        run <= 1'h1;
        repeat (30) @(posedge clock);
        chk({pin_out, timer_gate_result}, 2'h3);
        complete_run(0);
    end
endmodule
